/* scr_defs.svh */
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// I/O bus offsets of the register bank
`define SCR_OFF_RSN_PRI 12'h80A
`define SCR_OFF_MEM_ID 12'h80B
`define SCR_OFF_HB_CLR 12'h80C
`define SCR_OFF_MOD_CTL 12'h80D
`define SCR_OFF_RSN_RO 12'h80E
`define SCR_OFF_CACHE_CFG 12'h80F
`define SCR_OFF_RSN_TST 12'h82E

// Module control field positions
`define SCR_CTL_WIN_LO 0
`define SCR_CTL_WIN_HI 1
`define SCR_CTL_FLASH_WE 2
`define SCR_CTL_FLASH_SW 3
`define SCR_CTL_WDOG_EN 5
`define SCR_CTL_GATE_INV 7

// Reset cause field positions
`define SCR_RSN_WDOG 0
`define SCR_RSN_PANEL 1
`define SCR_RSN_BACKPLANE 2
`define SCR_RSN_POWER 3
`define SCR_RSN_DIAG 4

// Reset values and cause bit masks
`define SCR_CTL_RESET 8'h00
`define SCR_RSN_RESET 5'h00
`define SCR_RSN_ALL 5'h1F
`define SCR_RSN_CAUSE_MASK 5'h0F

// Backup cache codes
`define SCR_CACHE_OFF 3'h0
`define SCR_CACHE_2MB_12NS 3'h2

`endif

/* scr_pkg.sv */
package scr_pkg;

  // Host request on the local I/O bus
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } scr_io_req_t;

  // Read answer to the host
  typedef struct packed {
    logic rvalid;
    logic [31:0] rdata;
  } scr_io_rsp_t;

  // Reset events toward the cause register
  typedef struct packed {
    logic wdog;
    logic panel;
    logic backplane;
  } scr_rst_evt_t;

  // Decoded register select
  typedef enum logic [2:0] {
    SCR_SEL_NONE,
    SCR_SEL_RSN_PRI,
    SCR_SEL_MEM_ID,
    SCR_SEL_HB_CLR,
    SCR_SEL_MOD_CTL,
    SCR_SEL_RSN_RO,
    SCR_SEL_CACHE_CFG,
    SCR_SEL_RSN_TST
  } scr_sel_t;

endpackage

/* scr_rst_cause.sv */
`timescale 1ns/1ps
`include "scr_defs.svh"

// Reset cause bits; survive the system reset, cleared by power-on, and bits 3:0 also by a primary-alias write
module scr_rst_cause (
  input wire logic core_clk,
  input wire logic por_nrst,
  input wire scr_pkg::scr_rst_evt_t evt,
  input wire logic wr_clear,
  input wire logic wr_set,
  output logic [4:0] cause
);
  import scr_pkg::*;

  logic [4:0] cause_reg; // Stored cause bits
  logic [4:0] cause_next;
  logic por_seen_reg; // Power-up already recorded
  logic por_seen_next;

  // Next cause: set events win over software clear
  always_comb begin
    cause_next = cause_reg;
    por_seen_next = 1'b1;
    if (wr_clear) begin
      cause_next = cause_reg & ~`SCR_RSN_CAUSE_MASK;
    end
    if (wr_set) begin
      cause_next = `SCR_RSN_ALL;
    end
    if (evt.wdog) begin
      cause_next[`SCR_RSN_WDOG] = 1'b1;
    end
    if (evt.panel) begin
      cause_next[`SCR_RSN_PANEL] = 1'b1;
    end
    if (evt.backplane) begin
      cause_next[`SCR_RSN_BACKPLANE] = 1'b1;
    end
    if (!por_seen_reg) begin
      cause_next[`SCR_RSN_POWER] = 1'b1;
    end
  end

  // Only power-on clears; system reset leaves the bits alone
  always_ff @(posedge core_clk or negedge por_nrst) begin
    if (!por_nrst) begin
      cause_reg <= `SCR_RSN_RESET;
      por_seen_reg <= 1'b0;
    end else begin
      cause_reg <= cause_next;
      por_seen_reg <= por_seen_next;
    end
  end

  assign cause = cause_reg;

endmodule

/* scr_top.sv */
`timescale 1ns/1ps
`include "scr_defs.svh"

// Functional notes
// - Memory identity read-only, shows DIMM ID bits
// - Heartbeat rising edge sets heartbeat status
// - Heartbeat status drives heartbeat interrupt line
// - Any heartbeat-clear write clears status
// - System reset zeroes whole module control
// - Bits 1:0 select one 1 MB window
// - Window select comes up as 00
// - Bit 2 set drives flash write enable
// - Bit 3 shows flash-update switch, read-only
// - Switch low keeps flash write disabled
// - Bit 5 lets watchdog expiry reset module
// - Bit 7 inverts counter0 gate polarity
// - Cache config read-only three-bit code
// - Reset cause seen at three aliases
// - Primary clears causes; second alias read-only
// - Test alias write sets all five bits
// - Watchdog cause set on expiry only while bit 5 is set
// - Bits 1-3 record panel, backplane, power-up
// - Diagnostics flag blocks every module reset
module scr_top #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  // Clock and the two resets
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic por_nrst,
  // Host access on the local I/O bus
  input wire scr_pkg::scr_io_req_t io_req,
  output scr_pkg::scr_io_rsp_t io_rsp,
  // Board pins, all asynchronous to core_clk
  input wire logic heartbeat_in,
  input wire logic [7:0] dimm_id_in,
  input wire logic flash_switch_in,
  input wire logic [2:0] cache_code_in,
  input wire logic wdog_expire_in,
  input wire logic panel_rst_in,
  input wire logic backplane_rst_in,
  input wire logic counter0_gate_in,
  // Board outputs, all registered
  output logic hb_irq,
  output logic [1:0] flash_window,
  output logic flash_write_en,
  output logic counter0_gate,
  output logic module_rst_req
);
  import scr_pkg::*;

  // Elaboration check: offsets need 12 bits, control needs 8 data bits
  // The decode compares full 12-bit offsets, so a narrower bus would alias
  // registers; a data bus under 8 bits could not reach the control bits
  if (ADDR_W != 12 || DATA_W < 8 || DATA_W > 32) begin : g_bad_params
    $error("scr_top: ADDR_W must be 12 and DATA_W 8..32");
  end

  // Pin index inside the synchroniser vector
  // Single-bit pins sit at the bottom, the two code groups above them;
  // SY_W must match the width of the concatenation that feeds pin_raw
  localparam int SY_HB = 0;
  localparam int SY_SW = 1;
  localparam int SY_WD = 2;
  localparam int SY_PN = 3;
  localparam int SY_BP = 4;
  localparam int SY_GT = 5;
  localparam int SY_ID = 6;
  localparam int SY_CC = 14;
  localparam int SY_W = 17;

  // Decode an offset to a register select
  // Shared by the write and read sides so both always agree on the map;
  // any offset not listed selects nothing and is ignored or reads zero
  function automatic scr_sel_t dec_sel(input logic [11:0] a);
    case (a)
      `SCR_OFF_RSN_PRI: dec_sel = SCR_SEL_RSN_PRI;
      `SCR_OFF_MEM_ID: dec_sel = SCR_SEL_MEM_ID;
      `SCR_OFF_HB_CLR: dec_sel = SCR_SEL_HB_CLR;
      `SCR_OFF_MOD_CTL: dec_sel = SCR_SEL_MOD_CTL;
      `SCR_OFF_RSN_RO: dec_sel = SCR_SEL_RSN_RO;
      `SCR_OFF_CACHE_CFG: dec_sel = SCR_SEL_CACHE_CFG;
      `SCR_OFF_RSN_TST: dec_sel = SCR_SEL_RSN_TST;
      default: dec_sel = SCR_SEL_NONE;
    endcase
  endfunction

  // Pin synchronisers
  // Every board pin crosses into core_clk here before any logic reads it;
  // a third stage keeps last cycle's level for the edge detectors.
  // Levels and codes are read from the second stage only.
  logic [SY_W-1:0] pin_raw; // All asynchronous pins gathered
  logic [SY_W-1:0] sy1_reg; // First stage, read only by second
  logic [SY_W-1:0] sy2_reg; // Second stage, safe to use
  logic [SY_W-1:0] sy3_reg; // Delayed copy for edge detect

  assign pin_raw = {cache_code_in, dimm_id_in, counter0_gate_in, backplane_rst_in,
                    panel_rst_in, wdog_expire_in, flash_switch_in, heartbeat_in};

  // Two-flop synchroniser plus history stage
  // Cleared by the system reset; event pins idle low, so no false edge
  // appears when reset is released
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
      sy3_reg <= '0;
    end else begin
      sy1_reg <= pin_raw;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  // Rising edges of the event pins, one per bit
  // Each edge lasts exactly one cycle, so a held pin acts only once;
  // pins used as levels simply leave their edge bit unread
  logic [SY_W-1:0] rise;
  genvar gi;
  generate
    for (gi = 0; gi < SY_W; gi++) begin : g_rise
      assign rise[gi] = sy2_reg[gi] & ~sy3_reg[gi];
    end
  endgenerate

  // Bus decode
  // A strobe is acted on in the cycle it is sampled; the host never
  // waits, so there is no ready signal to return
  scr_sel_t wr_sel; // Target of a write this cycle
  scr_sel_t rd_sel; // Target of a read this cycle

  // Same decode for both directions
  // A write and a read in one cycle both act, both on the one shared offset
  always_comb begin
    wr_sel = io_req.wr ? dec_sel(io_req.addr) : SCR_SEL_NONE;
    rd_sel = io_req.rd ? dec_sel(io_req.addr) : SCR_SEL_NONE;
  end

  // Reset cause register (kept on power-on reset only)
  // These bits must outlive the module reset they record, so the
  // system reset does not reach them; only power-on clears them
  logic [4:0] cause; // Current cause bits
  logic diag_in_progress; // Diagnostics flag, blocks resets
  scr_rst_evt_t rst_evt; // Events that actually reset the module
  logic ctl_wdog_en; // Watchdog reset enable bit

  assign diag_in_progress = cause[`SCR_RSN_DIAG];

  // Qualify events; blocked ones do not record or reset
  // While diagnostics run nothing may reset the module, and a cause that
  // did not cause a reset is not recorded either
  always_comb begin
    rst_evt.wdog = rise[SY_WD] & ctl_wdog_en & ~diag_in_progress;
    rst_evt.panel = rise[SY_PN] & ~diag_in_progress;
    rst_evt.backplane = rise[SY_BP] & ~diag_in_progress;
  end

  // Aliases share one set of bits
  scr_rst_cause u_cause (
    .core_clk(core_clk),
    .por_nrst(por_nrst),
    .evt(rst_evt),
    .wr_clear(wr_sel == SCR_SEL_RSN_PRI),
    .wr_set(wr_sel == SCR_SEL_RSN_TST),
    .cause(cause)
  );

  // Module control register
  // Holds the flash window, flash write, watchdog and gate controls;
  // every system reset returns it to zero
  logic [7:0] ctl_reg; // Writable control bits
  logic [7:0] ctl_next;

  // Software write; switch bit and undefined bits not stored
  // Bit 3 is rebuilt from the switch on every read, so storing it would
  // only let a stale value leak out; bits 4 and 6 always read zero
  always_comb begin
    ctl_next = ctl_reg;
    if (wr_sel == SCR_SEL_MOD_CTL) begin
      ctl_next = io_req.wdata[7:0];
      ctl_next[`SCR_CTL_FLASH_SW] = 1'b0;
      ctl_next[4] = 1'b0;
      ctl_next[6] = 1'b0;
    end
  end

  // Cleared on every system reset
  // Window bits 00 select the boot image after any reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= `SCR_CTL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign ctl_wdog_en = ctl_reg[`SCR_CTL_WDOG_EN];

  // Heartbeat status
  // One flag, set by each tick of the heartbeat pin and dropped by a
  // write of any data to the clear offset
  logic hb_reg; // Heartbeat status flag
  logic hb_next;

  // Edge sets, any write clears; set wins on a tie
  // Letting the edge win means a tick that lands on the clear write is
  // never lost; software simply sees the request again
  always_comb begin
    hb_next = hb_reg;
    if (wr_sel == SCR_SEL_HB_CLR) begin
      hb_next = 1'b0;
    end
    if (rise[SY_HB]) begin
      hb_next = 1'b1;
    end
  end

  // Status flag register
  // Cleared by the system reset, so no request survives it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hb_reg <= 1'b0;
    end else begin
      hb_reg <= hb_next;
    end
  end

  // Interrupt line straight from the flag
  assign hb_irq = hb_reg;

  // Outputs to the flash, timer and reset logic
  // Each output is a flop fed from the control bits and the synchronised
  // pins, so none of them follows a bus strobe combinationally
  logic [1:0] win_reg; // Flash window select
  logic we_reg; // Flash write enable
  logic gate_reg; // Counter0 gate after polarity
  logic mrst_reg; // Module reset request pulse
  logic [1:0] win_next;
  logic we_next;
  logic gate_next;
  logic mrst_next;

  // Output values from control bits and events
  // The switch gates write enable in hardware, so a stray software write
  // cannot unlock the flash while the switch is off
  always_comb begin
    win_next = ctl_reg[`SCR_CTL_WIN_HI:`SCR_CTL_WIN_LO];
    we_next = ctl_reg[`SCR_CTL_FLASH_WE] & sy2_reg[SY_SW];
    gate_next = sy2_reg[SY_GT] ^ ctl_reg[`SCR_CTL_GATE_INV];
    mrst_next = rst_evt.wdog | rst_evt.panel | rst_evt.backplane;
  end

  // Output flops
  // Registering them keeps decode glitches off the board pins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      win_reg <= 2'h0;
      we_reg <= 1'b0;
      gate_reg <= 1'b0;
      mrst_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
      we_reg <= we_next;
      gate_reg <= gate_next;
      mrst_reg <= mrst_next;
    end
  end

  assign flash_window = win_reg;
  assign flash_write_en = we_reg;
  assign counter0_gate = gate_reg;
  assign module_rst_req = mrst_reg;

  // Read path
  // Read data is registered: it stands in the cycle after the strobe,
  // beside a one-cycle answer pulse
  logic [31:0] rdata_reg; // Registered read data
  logic rvalid_reg; // Read answer strobe
  logic [31:0] rdata_next;
  logic rvalid_next;
  logic [7:0] ctl_view; // Control as software sees it

  // Switch state merged into bit 3
  always_comb begin
    ctl_view = ctl_reg;
    ctl_view[`SCR_CTL_FLASH_SW] = sy2_reg[SY_SW];
  end

  // Read mux; unmapped offsets and write-only clear read zero
  // All three cause aliases return the same bits; only their write
  // behaviour differs
  always_comb begin
    rdata_next = 32'h0000_0000;
    rvalid_next = io_req.rd;
    case (rd_sel)
      SCR_SEL_RSN_PRI: begin
        rdata_next[4:0] = cause;
      end
      SCR_SEL_RSN_RO: begin
        rdata_next[4:0] = cause;
      end
      SCR_SEL_RSN_TST: begin
        rdata_next[4:0] = cause;
      end
      SCR_SEL_MEM_ID: begin
        rdata_next[7:0] = sy2_reg[SY_ID+7:SY_ID];
      end
      SCR_SEL_MOD_CTL: begin
        rdata_next[7:0] = ctl_view;
      end
      SCR_SEL_CACHE_CFG: begin
        rdata_next[2:0] = sy2_reg[SY_CC+2:SY_CC];
      end
      SCR_SEL_HB_CLR: begin
        rdata_next = 32'h0000_0000;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
    if (DATA_W < 32) begin
      rdata_next = rdata_next & ((32'h1 << DATA_W) - 32'h1);
    end
  end

  // Answer one cycle after the read
  // rdata holds for one cycle beside the rvalid pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign io_rsp = '{rvalid: rvalid_reg, rdata: rdata_reg};

endmodule

/* scr_top_properties.sv */
`timescale 1ns/1ps
// Port-level checks of the register bank
module scr_top_properties (
  input wire logic core_clk,
  input wire logic nrst,
  input wire scr_pkg::scr_io_req_t io_req,
  input wire scr_pkg::scr_io_rsp_t io_rsp,
  input wire logic heartbeat_in,
  input wire logic flash_switch_in,
  input wire logic wdog_expire_in,
  input wire logic panel_rst_in,
  input wire logic backplane_rst_in,
  input wire logic hb_irq,
  input wire logic [1:0] flash_window,
  input wire logic flash_write_en,
  input wire logic module_rst_req
);
  import scr_pkg::*;
  logic [7:0] evt_hist; // Recent reset-source pin levels
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Shift history of any reset source
  always_ff @(posedge core_clk) begin
    evt_hist <= {evt_hist[6:0], wdog_expire_in | panel_rst_in | backplane_rst_in};
  end
  a_reset_zero: assert property ($rose(nrst) |-> flash_window == 2'h0 && !flash_write_en && !hb_irq)
    else $error("outputs not cleared by reset");
  a_win_follow: assert property (io_req.wr && io_req.addr == 12'h80D |->
    ##2 flash_window == $past(io_req.wdata[1:0], 2))
    else $error("flash window does not follow control write");
  a_write_gate: assert property (!flash_switch_in [*6] |-> !flash_write_en)
    else $error("flash write enabled with switch off");
  a_rvalid_one: assert property (io_req.rd |=> io_rsp.rvalid)
    else $error("read without answer");
  a_rvalid_src: assert property (io_rsp.rvalid |-> $past(io_req.rd))
    else $error("answer without read");
  a_hb_set: assert property ($rose(heartbeat_in) |-> ##[2:6] hb_irq)
    else $error("heartbeat edge did not raise request");
  a_hb_clear: assert property (!heartbeat_in [*6] ##0 (io_req.wr && io_req.addr == 12'h80C)
    |=> !hb_irq)
    else $error("heartbeat clear write ignored");
  a_rst_pulse: assert property (module_rst_req |=> !module_rst_req)
    else $error("module reset request longer than one cycle");
  a_rst_cause: assert property (module_rst_req |-> evt_hist != 8'h00)
    else $error("module reset request without a source");
endmodule

/* scr_host_model.sv */
`timescale 1ns/1ps
// Host side of the local I/O bus
module scr_host_model (
  input wire logic core_clk,
  output scr_pkg::scr_io_req_t io_req,
  input wire scr_pkg::scr_io_rsp_t io_rsp
);
  import scr_pkg::*;
  // Idle bus at time zero
  initial io_req = '{wr: 1'b0, rd: 1'b0, addr: 12'hFFF, wdata: 32'h5A5A5A5A};
  // Release: strobes low, address and data scrambled
  task automatic drop();
    io_req.wr = 1'b0;
    io_req.rd = 1'b0;
    io_req.addr = ~io_req.addr;
    io_req.wdata = ~io_req.wdata;
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    io_req.addr = a;
    io_req.wdata = d;
    io_req.wr = 1'b1;
    @(posedge core_clk);
    #1;
    drop();
  endtask
  // Read; answer stands in the cycle after the taking edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk);
    #1;
    io_req.addr = a;
    io_req.rd = 1'b1;
    @(posedge core_clk);
    #1;
    drop();
    d = (io_rsp.rvalid === 1'b1) ? io_rsp.rdata : 32'hXXXXXXXX;
  endtask
endmodule

/* system_control_registers_tb_top.sv */
`timescale 1ns/1ps
module system_control_registers_tb_top;
  import scr_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic por_nrst = 1'b0;
  scr_io_req_t io_req;
  scr_io_rsp_t io_rsp;
  logic heartbeat_in = 1'b0; // Square wave from the timekeeping chip
  logic flash_switch_in = 1'b1;
  logic [2:0] cache_code_in = 3'h0;
  logic [7:0] dimm_id_in = 8'hA5; // DIMM identity pins
  logic [2:0] evt_pins = 3'h0; // Watchdog, panel, backplane
  logic counter0_gate_in = 1'b0;
  logic hb_irq, flash_write_en, counter0_gate, module_rst_req;
  logic [1:0] flash_window;
  int bad_count = 0;
  int checks = 0;
  int rst_cnt = 0; // Module reset requests seen
  int exp_rst = 0;
  always #5 core_clk = ~core_clk;
  // Count reset request pulses
  always @(posedge core_clk) if (module_rst_req === 1'b1) rst_cnt <= rst_cnt + 1;
  scr_host_model host_u (.core_clk(core_clk), .io_req(io_req), .io_rsp(io_rsp));
  scr_top dut_u (.core_clk(core_clk), .nrst(nrst), .por_nrst(por_nrst), .io_req(io_req),
    .io_rsp(io_rsp), .heartbeat_in(heartbeat_in), .dimm_id_in(dimm_id_in),
    .flash_switch_in(flash_switch_in), .cache_code_in(cache_code_in),
    .wdog_expire_in(evt_pins[0]), .panel_rst_in(evt_pins[1]),
    .backplane_rst_in(evt_pins[2]), .counter0_gate_in(counter0_gate_in), .hb_irq(hb_irq),
    .flash_window(flash_window), .flash_write_en(flash_write_en),
    .counter0_gate(counter0_gate), .module_rst_req(module_rst_req));
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read and compare
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    host_u.rd(a, d);
    chk("rdata", e, d);
  endtask
  // Reset source pin pulse
  task automatic ev(input int k);
    evt_pins[k] = 1'b1;
    step(4);
    evt_pins[k] = 1'b0;
    step(6);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end
  initial begin
    step(8);
    nrst = 1'b1;
    por_nrst = 1'b1;
    step(2);
    rc(12'h80D, 32'h08);
    rc(12'h80A, 32'h08);
    rc(12'h80B, 32'hA5);
    dimm_id_in = 8'h5A;
    step(4);
    rc(12'h80B, 32'h5A);
    rc(12'h80C, 32'h00);
    rc(12'h800, 32'h00);
    for (int c = 0; c < 8; c++) begin
      cache_code_in = c[2:0];
      step(4);
      rc(12'h80F, c);
    end
    host_u.wr(12'h80F, 32'h0);
    rc(12'h80F, 32'h07);
    $display("test ids done");
    host_u.wr(12'h80D, 32'hFFFFFFFF);
    rc(12'h80D, 32'hAF);
    chk("flash_write_en", 1, flash_write_en);
    chk("counter0_gate", 1, counter0_gate);
    flash_switch_in = 1'b0;
    step(6);
    chk("flash_write_en", 0, flash_write_en);
    rc(12'h80D, 32'hA7);
    counter0_gate_in = 1'b1;
    step(4);
    chk("counter0_gate", 0, counter0_gate);
    host_u.wr(12'h80B, 32'h0);
    rc(12'h80B, 32'h5A);
    for (int w = 0; w < 4; w++) begin
      host_u.wr(12'h80D, w);
      step(2);
      chk("flash_window", w, flash_window);
    end
    $display("test control done");
    heartbeat_in = 1'b1;
    step(8);
    chk("hb_irq", 1, hb_irq);
    heartbeat_in = 1'b0;
    step(8);
    host_u.wr(12'h80C, 32'h12345678);
    step(1);
    chk("hb_irq", 0, hb_irq);
    $display("test heartbeat done");
    host_u.wr(12'h80D, 32'h0);
    host_u.wr(12'h80A, 32'h0);
    rc(12'h80A, 32'h00);
    ev(1);
    exp_rst++;
    rc(12'h80A, 32'h02);
    ev(2);
    exp_rst++;
    rc(12'h80A, 32'h06);
    ev(0);
    rc(12'h80A, 32'h06);
    host_u.wr(12'h80D, 32'h20);
    ev(0);
    exp_rst++;
    rc(12'h80A, 32'h07);
    chk("rst_cnt", exp_rst, rst_cnt);
    rc(12'h80E, 32'h07);
    host_u.wr(12'h80E, 32'h0);
    rc(12'h80A, 32'h07);
    host_u.wr(12'h80A, 32'hFF);
    rc(12'h80A, 32'h00);
    host_u.wr(12'h82E, 32'h0);
    rc(12'h80A, 32'h1F);
    host_u.wr(12'h80A, 32'h0);
    rc(12'h80A, 32'h10);
    ev(1);
    ev(0);
    rc(12'h80A, 32'h10);
    chk("rst_cnt", exp_rst, rst_cnt);
    $display("test causes done");
    host_u.wr(12'h80D, 32'hA3);
    step(2);
    chk("flash_window", 3, flash_window);
    chk("counter0_gate", 0, counter0_gate);
    nrst = 1'b0;
    step(3);
    nrst = 1'b1;
    step(2);
    chk("flash_window", 0, flash_window);
    rc(12'h80D, 32'h00);
    rc(12'h80A, 32'h10);
    chk("counter0_gate", 1, counter0_gate);
    $display("test reset done");
    finish_test();
  end
endmodule
bind scr_top scr_top_properties chk_u (.core_clk(core_clk), .nrst(nrst), .io_req(io_req),
  .io_rsp(io_rsp), .heartbeat_in(heartbeat_in), .flash_switch_in(flash_switch_in),
  .wdog_expire_in(wdog_expire_in), .panel_rst_in(panel_rst_in),
  .backplane_rst_in(backplane_rst_in), .hb_irq(hb_irq), .flash_window(flash_window),
  .flash_write_en(flash_write_en), .module_rst_req(module_rst_req));
